//--- core/bwp_protect_map.sv
// block write protection map: apb register slave, status register and the
// array write gate that merges pin and software block protection.
// assumes the pins are synchronous to pclk and undriven pins arrive low.
// assumes the host holds each request steady until pready.
//
// What this block does
// - 64Mb array: address bit 23 must be zero, bits 22..0 select.
// - decode status, config, interrupt, ecc, flag and id register offsets.
// - lowest 256 addresses form eight 32-byte sections numbered 0 to 7.
// - all hardware code pins low gives no hardware protection.
// - any hardware code pin high rejects writes inside its region.
// - hardware side select low puts region at the array top.
// - hardware side select high puts region at address zero.
// - undriven hardware pins count as low, leaving software protection only.
// - top code 001..111 protects upper 1/64 up to whole array.
// - bottom code protects lower 1/64 up to whole array from zero.
// - status bit 7 enables write-protect pin checking, active low pin.
// - status bit 5 picks software side: one bottom, zero top.
// - status bits 4..2 hold software code, reset zero means none.
// - status bit 1 shows write-enable latch, read only, reset zero.
// - status bits 6 and 0 read back as written, no effect.
// - address protected if hardware or software region covers it.
// - software top code maps like hardware code, changeable only while the latch is set and the pin guard is off.
// - latch clear blocks array, status and config writes; pin protect guards status and config.

`timescale 1ns/100ps
`default_nettype none

module bwp_protect_map
    import bwp_pkg::*;
#(
    parameter int unsigned ARRAY_ADDR_BITS = 23  // used array address bits
) (
    input  wire logic        pclk,         // bus clock, 50 MHz
    input  wire logic        presetn,      // async reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction, high write
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    input  wire logic [3:0]  pstrb,        // apb byte strobes
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error, unmapped address
    input  wire bwp_pins_t   pins,         // protection pins
    output logic             array_write,  // array write accepted, pulse
    output logic [ADDR_W-1:0] array_addr,  // address of accepted write
    output logic [7:0]       array_data    // data of accepted write
);

    // -------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------
    if (ARRAY_ADDR_BITS != ARRAY_BITS) begin : g_bad_width
        $error("bwp_protect_map serves only a 23-bit array");
    end
    // the range check reads one spare bit above the used ones
    if (ADDR_W != ARRAY_ADDR_BITS + 1) begin : g_bad_addr
        $error("bwp_protect_map needs a 24-bit array address");
    end

    // -------------------------------------------------------------------
    // protection functions
    // -------------------------------------------------------------------
    // region check shared by the pin code and the software code; a code
    // n protects 1/2^(7-n) of the array, seven means everything
    // a loop over leading bits stands in for two eight-entry tables;
    // top and bottom differ only in the bit value that must match
    function automatic logic in_region(input logic [2:0]  code,
                                       input logic        bottom,
                                       input logic [22:0] a);
        logic [2:0] span;
        logic       hit;
        span = 3'h0;
        hit  = 1'b0;
        if (code == 3'h0) begin
            hit = 1'b0;
        end else if (code == 3'h7) begin
            hit = 1'b1;
        end else begin
            span = 3'h7 - code;  // leading address bits that must match
            hit  = 1'b1;
            for (int i = 0; i < 6; i++) begin
                if (i < int'(span)) begin
                    // top region: leading bits all one, bottom: all zero
                    if (a[22-i] == bottom) begin
                        hit = 1'b0;
                    end
                end
            end
        end
        return hit;
    endfunction

    // byte strobe merge for one 8-bit register in lane 0
    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       lane);
        return lane ? nw : old;
    endfunction

    // -------------------------------------------------------------------
    // register state
    // -------------------------------------------------------------------
    logic [7:0]  status_q;
    logic [7:0]  cfg_one_q;
    logic [7:0]  cfg_two_q;
    logic [7:0]  int_cfg_q;
    logic [7:0]  ecc_in_q;
    logic [7:0]  ecc_inj_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        arr_wr_q;
    logic [ADDR_W-1:0] arr_addr_q;
    logic [7:0]  arr_data_q;
    bwp_outcome_t outcome_q;
    // ecc output and error count have no storage in this block

    // identity code, value is arbitrary
    localparam logic [31:0] IDENT_VALUE = 32'h5a_2_1_0_1_01;

    // -------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------
    logic [7:0] widx;
    logic       setup;
    logic       wr_go;
    logic       mapped;
    logic       wel;
    logic       pin_guard;
    logic       reg_locked;
    // one aligned word per register; paddr[1:0] are ignored
    assign widx  = paddr[9:2];
    assign setup = psel && !penable;
    // the write lands at the setup edge; pready answers one cycle later
    assign wr_go = setup && pwrite;

    always_comb begin
        unique case (widx)
            IDX_STATUS, IDX_CFG_ONE, IDX_CFG_TWO, IDX_INT_CFG,
            IDX_ECC_IN, IDX_ECC_INJ, IDX_ECC_OUT, IDX_ECC_CNT,
            IDX_FLAG, IDX_IDENT, IDX_WEL_CTRL, IDX_ARR_WR,
            IDX_ARR_RES, IDX_PINS: mapped = (paddr[11:10] == 2'b00);
            default:               mapped = 1'b0;
        endcase
    end

    assign wel       = status_q[POS_WEL];
    assign pin_guard = status_q[POS_PIN_EN] && !pins.write_protect_n;
    assign reg_locked = !wel || pin_guard;

    // -------------------------------------------------------------------
    // array write protection decision
    // -------------------------------------------------------------------
    logic [ADDR_W-1:0] req_addr;
    logic [2:0]        hw_code;
    logic              hw_hit;
    logic              sw_hit;
    logic              range_bad;
    logic              arr_req;
    // the array write word carries the address above the data byte
    assign req_addr = pwdata[31:8];
    assign arr_req  = wr_go && (widx == IDX_ARR_WR) && mapped;
    // pulled-low pins read as zero code, no hardware region
    // pins arrive synchronous to pclk, so no synchroniser is kept
    assign hw_code  = {pins.hw_protect_code_bit2, pins.hw_protect_code_bit1,
                       pins.hw_protect_code_bit0};
    // bit 23 must be clear
    // out of range for this density; reported apart from a block
    assign range_bad = req_addr[ADDR_W-1];
    assign hw_hit = in_region(hw_code, pins.hw_region_side_select,
                              req_addr[22:0]);
    assign sw_hit = in_region(status_q[POS_CODE_HI:POS_CODE_LO],
                              status_q[POS_SW_SIDE], req_addr[22:0]);

    logic arr_ok;
    assign arr_ok = arr_req && wel && !range_bad && !hw_hit && !sw_hit;

    // accepted write pulse, one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arr_wr_q <= 1'b0;
        end else begin
            arr_wr_q <= arr_ok;
        end
    end

    // rejects store nothing
    // levels are taken live at the setup edge, never latched before
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arr_addr_q <= '0;
            arr_data_q <= 8'h00;
        end else if (arr_ok) begin
            arr_addr_q <= req_addr;
            arr_data_q <= pwdata[7:0];
        end
    end

    // -------------------------------------------------------------------
    // array write outcome
    // -------------------------------------------------------------------
    // outcome of the last attempt, with section number for low addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outcome_q <= '0;
        end else if (arr_req) begin
            outcome_q.addr <= req_addr;
            // 32-byte sections in the lowest 256 addresses
            outcome_q.section <= req_addr[SEC_TOP_BIT:5];
            outcome_q.in_section_space <= (req_addr[23:8] == 16'h0000);
            if (range_bad) begin
                outcome_q.result <= BWP_RES_RANGE;
            end else if (!wel || hw_hit || sw_hit) begin
                outcome_q.result <= BWP_RES_BLOCK;
            end else begin
                outcome_q.result <= BWP_RES_DONE;
            end
        end
    end

    // -------------------------------------------------------------------
    // status register and latch
    // -------------------------------------------------------------------
    // latch read only here
    // locked writes drop
    // the latch moves only through its private control word, which stays
    // writable so software can always recover from a cleared latch
    // bit 1 keeps the latch; every other bit is taken as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= STATUS_RST;
        end else if (wr_go && mapped && pstrb[0]) begin
            if (widx == IDX_WEL_CTRL) begin
                status_q[POS_WEL] <= pwdata[0];
            end else if (widx == IDX_STATUS && !reg_locked) begin
                status_q <= {pwdata[7:2], status_q[POS_WEL], pwdata[0]};
            end
        end
    end

    // -------------------------------------------------------------------
    // configuration group
    // -------------------------------------------------------------------
    // same lock as status
    logic cfg_go;
    assign cfg_go = wr_go && mapped && !reg_locked;

    // config one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_one_q <= CFG_RST;
        end else if (cfg_go && widx == IDX_CFG_ONE) begin
            cfg_one_q <= merge8(cfg_one_q, pwdata[7:0], pstrb[0]);
        end
    end

    // config two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_two_q <= CFG_RST;
        end else if (cfg_go && widx == IDX_CFG_TWO) begin
            cfg_two_q <= merge8(cfg_two_q, pwdata[7:0], pstrb[0]);
        end
    end

    // interrupt config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_cfg_q <= CFG_RST;
        end else if (cfg_go && widx == IDX_INT_CFG) begin
            int_cfg_q <= merge8(int_cfg_q, pwdata[7:0], pstrb[0]);
        end
    end

    // ecc test input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecc_in_q <= CFG_RST;
        end else if (cfg_go && widx == IDX_ECC_IN) begin
            ecc_in_q <= merge8(ecc_in_q, pwdata[7:0], pstrb[0]);
        end
    end

    // ecc error injection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ecc_inj_q <= CFG_RST;
        end else if (cfg_go && widx == IDX_ECC_INJ) begin
            ecc_inj_q <= merge8(ecc_inj_q, pwdata[7:0], pstrb[0]);
        end
    end

    // -------------------------------------------------------------------
    // read mux and bus answer
    // -------------------------------------------------------------------
    logic [31:0] rd_val;
    // ecc engine lives elsewhere; its outputs read as zero here
    // unmapped words read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (widx)
            IDX_STATUS:   rd_val = {24'h0, status_q};
            IDX_CFG_ONE:  rd_val = {24'h0, cfg_one_q};
            IDX_CFG_TWO:  rd_val = {24'h0, cfg_two_q};
            IDX_INT_CFG:  rd_val = {24'h0, int_cfg_q};
            IDX_ECC_IN:   rd_val = {24'h0, ecc_in_q};
            IDX_ECC_INJ:  rd_val = {24'h0, ecc_inj_q};
            IDX_FLAG:     rd_val = {24'h0, FLAG_READY};
            IDX_IDENT:    rd_val = IDENT_VALUE;
            IDX_WEL_CTRL: rd_val = {31'h0, wel};
            IDX_ARR_RES:  rd_val = {2'b00, outcome_q};
            IDX_PINS:     rd_val = {27'h0, pins};
            default:      rd_val = 32'h0000_0000;
        endcase
        if (!mapped) begin
            rd_val = 32'h0000_0000;
        end
    end

    // no wait state: answer in the first access cycle after every setup;
    // a fixed latency keeps the slave free of any wait counter
    // unmapped answers error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !mapped;
        end
    end

    // read data captured in setup, held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_val;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    // each port copies a flip-flop, so no decode glitch reaches a pin
    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign array_write = arr_wr_q;
    assign array_addr  = arr_addr_q;
    assign array_data  = arr_data_q;

endmodule // bwp_protect_map

`default_nettype wire

//--- core/bwp_pkg.sv
// package for the block write protection map: register offsets, status
// field positions, reset values and the packed carriers shared by files.
// assumes a 32-bit apb register bus and a 24-bit array address space.

package bwp_pkg;

    // -------------------------------------------------------------------
    // register word indices; the byte address is four times the index
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS   = 8'h00;
    localparam logic [7:0] IDX_CFG_ONE  = 8'h02;
    localparam logic [7:0] IDX_CFG_TWO  = 8'h03;
    localparam logic [7:0] IDX_INT_CFG  = 8'h04;
    localparam logic [7:0] IDX_ECC_IN   = 8'h05;
    localparam logic [7:0] IDX_ECC_INJ  = 8'h06;
    localparam logic [7:0] IDX_ECC_OUT  = 8'h07;
    localparam logic [7:0] IDX_ECC_CNT  = 8'h08;
    localparam logic [7:0] IDX_FLAG     = 8'h0a;
    localparam logic [7:0] IDX_IDENT    = 8'h30;
    // block-private registers
    localparam logic [7:0] IDX_WEL_CTRL = 8'h40;
    localparam logic [7:0] IDX_ARR_WR   = 8'h41;
    localparam logic [7:0] IDX_ARR_RES  = 8'h42;
    localparam logic [7:0] IDX_PINS     = 8'h43;

    // -------------------------------------------------------------------
    // status field positions and reset values
    // -------------------------------------------------------------------
    localparam int POS_PIN_EN   = 7;
    localparam int POS_SW_SIDE  = 5;
    localparam int POS_CODE_HI  = 4;
    localparam int POS_CODE_LO  = 2;
    localparam int POS_WEL      = 1;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [7:0] FLAG_READY = 8'h80;

    // array geometry: 64Mb, 23 address bits used of 24
    localparam int ADDR_W       = 24;
    localparam int ARRAY_BITS   = 23;
    localparam int SEC_TOP_BIT  = 7;

    // array write outcome codes
    typedef enum logic [1:0] {
        BWP_RES_NONE  = 2'b00,
        BWP_RES_DONE  = 2'b01,
        BWP_RES_BLOCK = 2'b10,
        BWP_RES_RANGE = 2'b11
    } bwp_res_t;

    // protection pins travel together
    typedef struct packed {
        logic       hw_region_side_select;
        logic       hw_protect_code_bit2;
        logic       hw_protect_code_bit1;
        logic       hw_protect_code_bit0;
        logic       write_protect_n;
    } bwp_pins_t;

    // outcome of one array write attempt
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0]        section;
        logic              in_section_space;
        bwp_res_t          result;
    } bwp_outcome_t;

endpackage : bwp_pkg

//--- tb/bwp_host.sv
// apb master model standing for the host controller on the far side.
// assumes a single pclk domain; one transfer at a time.
`timescale 1ns/100ps
`default_nettype none
module bwp_host (
    input  wire logic        pclk,    // bus clock
    output logic             psel,    // select
    output logic             penable, // access phase
    output logic             pwrite,  // direction
    output logic [11:0]      paddr,   // byte address
    output logic [31:0]      pwdata,  // write data
    output logic [3:0]       pstrb,   // byte strobes
    input  wire logic [31:0] prdata,  // read data
    input  wire logic        pready,  // ready
    input  wire logic        pslverr  // error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // setup, then access held until pready; released direction, address and data inverted
    // so a slave that samples late never sees stale data
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count is assumed; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= ~wr;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // bwp_host
`default_nettype wire

//--- tb/bwp_protect_map_checker.sv
// port checker for the protection map; bound at the foot of the file.
// assumes pins are steady around the setup edge of an array write.
`timescale 1ns/100ps
`default_nettype none
module bwp_protect_map_checker
    import bwp_pkg::*;
#(
    parameter int unsigned ARRAY_ADDR_BITS = 23 // used array address bits
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire bwp_pins_t   pins,
    input wire logic        array_write,
    input wire logic [23:0] array_addr,
    input wire logic [7:0]  array_data
);
    logic [3:0] hw; // side and code
    assign hw = {pins.hw_region_side_select, pins.hw_protect_code_bit2,
                 pins.hw_protect_code_bit1, pins.hw_protect_code_bit0};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // -----------------------------------------------------------------
    // bus and array write relations
    // -----------------------------------------------------------------
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable
        && $past(psel && !penable)) else $error("stray ready");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_reads_zero_a: assert property (pslverr && !pwrite
        |-> prdata == 32'h0) else $error("refused read not zero");
    wr_single_pulse_a: assert property (array_write |=> !array_write)
        else $error("array write longer than one cycle");
    wr_carries_req_a: assert property (array_write |-> pready
        && {array_addr, array_data} == $past(pwdata))
        else $error("array write not from request");
    wr_bit23_clear_a: assert property (array_write |-> !array_addr[23])
        else $error("address bit 23 accepted");
    wr_hold_a: assert property (!array_write |-> $stable(array_addr))
        else $error("array address moved without write");
    hw_all_block_a: assert property (array_write
        |-> $past(hw[2:0]) != 3'h7) else $error("write with all locked");
    hw_top_small_a: assert property (array_write && $past(hw) == 4'h1
        |-> array_addr < 24'h7e0000) else $error("top region written");
    hw_bot_small_a: assert property (array_write && $past(hw) == 4'h9
        |-> array_addr > 24'h01ffff) else $error("bottom region written");
    cv_write: cover property (array_write);
    cv_err: cover property (pslverr);
    cv_top: cover property (array_write && $past(hw) == 4'h1);
endmodule // bwp_protect_map_checker
bind bwp_protect_map bwp_protect_map_checker #(
    .ARRAY_ADDR_BITS(ARRAY_ADDR_BITS)) bwp_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins),
    .array_write(array_write), .array_addr(array_addr),
    .array_data(array_data));
`default_nettype wire

//--- tb/bwp_protect_map_tb.sv
// self-checking bench: host model drives apb, bench drives the pins.
// assumes the hand-over register map and result codes.
`timescale 1ns/100ps
`default_nettype none
module bwp_protect_map_tb;
    import bwp_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, aw;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [23:0] aa;
    logic [7:0] ad;
    bwp_pins_t pins;
    int n_mismatch = 0;
    int samples_checked = 0;
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;
    bwp_protect_map bwp_protect_map_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .array_write(aw),
        .array_addr(aa), .array_data(ad));
    bwp_host bwp_host_inst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // -----------------------------------------------------------------
    // shared tasks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bwp_host_inst.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        bwp_host_inst.xfer(1'b0, a, 32'h0, r, e);
    endtask
    // array write, then its result word
    task automatic arr(input logic [23:0] a, output logic [31:0] r);
        wr(12'h104, {a, 8'h5a});
        rd(12'h108, r);
    endtask
    task automatic res(input logic [23:0] a, input logic [1:0] exp);
        logic [31:0] r, was;
        was = {aa, ad};
        arr(a, r);
        check({30'h0, r[1:0]}, {30'h0, exp});
        check({aa, ad}, exp == BWP_RES_DONE ? {a, 8'h5a} : was);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(12'h000, r);
        check(r, 32'h0);
        rd(12'h028, r);
        check(r, 32'h80);
        bwp_host_inst.xfer(1'b0, 12'h0fc, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        wr(12'h000, 32'h04);
        rd(12'h000, r);
        check(r, 32'h0);
        res(24'h000010, BWP_RES_BLOCK);
    endtask
    task automatic t_status();
        logic [31:0] r;
        wr(12'h100, 32'h1);
        wr(12'h000, 32'h43);
        rd(12'h000, r);
        check(r, 32'h43);
        wr(12'h008, 32'ha5);
        rd(12'h008, r);
        check(r, 32'ha5);
        res(24'h7fffff, BWP_RES_DONE);
        res(24'h800000, BWP_RES_RANGE);
        arr(24'h0000e5, r);
        check({28'h0, r[5:2]}, 32'hf);
        wr(12'h000, 32'h00);
        rd(12'h000, r);
        check(r, 32'h02);
    endtask
    // each code and side at the region edge, pins or status
    task automatic t_region(input logic sw);
        logic [23:0] sz;
        for (int s = 0; s < 2; s++) begin
            for (int c = 1; c < 8; c++) begin
                sz = 24'h1 << (16 + c);
                @(posedge pclk);
                pins <= sw ? 5'h01 : {s[0], c[2:0], 1'b1};
                wr(12'h000, sw ? {26'h0, s[0], c[2:0], 2'b00} : 32'h0);
                if (s == 0) begin
                    res(24'h800000 - sz, BWP_RES_BLOCK);
                    if (c < 7) res(24'h7fffff - sz, BWP_RES_DONE);
                end else begin
                    res(sz - 24'h1, BWP_RES_BLOCK);
                    if (c < 7) res(sz, BWP_RES_DONE);
                end
            end
        end
        @(posedge pclk);
        pins <= 5'h01;
        wr(12'h000, 32'h0);
        res(24'h000000, BWP_RES_DONE);
    endtask
    task automatic t_merge();
        @(posedge pclk);
        pins <= 5'h03;
        wr(12'h000, 32'h24);
        res(24'h7fffff, BWP_RES_BLOCK);
        res(24'h000000, BWP_RES_BLOCK);
        res(24'h400000, BWP_RES_DONE);
    endtask
    task automatic t_pinlock();
        logic [31:0] r;
        @(posedge pclk);
        pins <= 5'h00;
        wr(12'h000, 32'h80);
        wr(12'h000, 32'h84);
        rd(12'h000, r);
        check(r, 32'h82);
        wr(12'h00c, 32'h3c);
        rd(12'h00c, r);
        check(r, 32'h0);
        @(posedge pclk);
        pins <= 5'h01;
        wr(12'h000, 32'h84);
        rd(12'h000, r);
        check(r, 32'h86);
        res(24'h7fffff, BWP_RES_BLOCK);
    endtask
    initial begin
        presetn = 1'b0;
        pins = 5'h01;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_status();
        t_region(1'b0);
        t_region(1'b1);
        t_merge();
        t_pinlock();
        end_of_test();
    end
    // watchdog well past the expected run of a few hundred cycles
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
endmodule // bwp_protect_map_tb
`default_nettype wire
